// [ddrp_top.sv]
// ddr3 command/address pin decoder with apb status and mode view
// assumes pins arrive asynchronously and are sampled by pclk
//
// Notes on behaviour
// - capture inputs on ck rising, ck_n falling crossing
// - cke high runs clocks, buffers, drivers
// - cke low: idle banks powerdown/selfrefresh, else active
// - self-refresh exit on cke without ck
// - power-down keeps only ck, ck_n, odt, cke
// - self-refresh keeps only cke receiver
// - cs_n high masks command; cs_n in code
// - odt terminates only data, strobe, mask
// - odt ignored when both rtt fields off
// - dm high drops write beat, both dqs edges
// - x8 mask/tdqs ball chosen by mode bit
// - bank address picks bank or mode register
// - a10 on read/write gives auto-precharge
// - precharge a10 low one bank, high all
// - in otf burst mode a12 low chops burst, high full burst
// - tdqs mode terminates tdqs like dqs
// - reset pin holds device reset asynchronously
//
// Implementation choices: the register offsets and the APB slave port.
`include "ddrp_params.svh"
`default_nettype none

module ddrp_top #(
  parameter int NBANK = 8
) (
  input wire logic pclk, // system clock, 40 MHz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire ddrp_pkg::ddrp_pins_type pins, // controller pins
  input wire logic reset_pin_n, // device reset pin
  output ddrp_pkg::ddrp_dec_type dec, // decoded command
  output logic [NBANK-1:0] bank_open, // open banks
  output ddrp_pkg::ddrp_pstate_type pstate, // power state
  output ddrp_pkg::ddrp_bufen_type bufen, // receiver enables
  output logic clk_run, // internal clocks on
  output logic drv_en, // output drivers on
  output logic term_data_en, // dq/dqs/dm termination
  output logic term_tdqs_en, // tdqs termination
  output logic dm_func_en, // ball acts as mask
  output logic beat_valid, // write beat seen
  output logic beat_masked // that beat is dropped
);

  // ------------------------------------------------------------
  // device reset
  // ------------------------------------------------------------
  logic rst_meta;
  logic dev_rstn;
  logic rst_any_n;

  assign rst_any_n = presetn & reset_pin_n;

  // asserts at once, releases after two pclk edges
  always_ff @(posedge pclk or negedge rst_any_n) begin
    if (!rst_any_n) begin
      rst_meta <= 1'b0;
      dev_rstn <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      dev_rstn <= rst_meta;
    end
  end

  // ------------------------------------------------------------
  // pin sampling
  // ------------------------------------------------------------
  ddrp_pkg::ddrp_pins_type pin_s;
  logic cross_q;
  logic dqs_q;
  logic crossing;
  logic ck_edge;
  logic dqs_edge;

  ddrp_sync #(
    .W($bits(ddrp_pkg::ddrp_pins_type))
  ) u_sync (
    .clk(pclk),
    .rstn(dev_rstn),
    .d(pins),
    .q(pin_s)
  );

  // crossing of ck rising and ck_n falling
  assign crossing = pin_s.ck & ~pin_s.ck_n;
  assign ck_edge = crossing & ~cross_q & bufen.clk;
  assign dqs_edge = (pin_s.dqs ^ dqs_q) & bufen.data;

  // edge history
  always_ff @(posedge pclk or negedge dev_rstn) begin
    if (!dev_rstn) begin
      cross_q <= 1'b0;
      dqs_q <= 1'b0;
    end else begin
      cross_q <= crossing;
      dqs_q <= pin_s.dqs;
    end
  end

  // ------------------------------------------------------------
  // receiver, clock and driver enables
  // ------------------------------------------------------------
  always_comb begin
    bufen.cke = 1'b1;
    bufen.clk = (pstate != ddrp_pkg::PS_SREF);
    bufen.odt = (pstate != ddrp_pkg::PS_SREF);
    bufen.cmd = (pstate == ddrp_pkg::PS_RUN);
    bufen.data = (pstate == ddrp_pkg::PS_RUN);
  end

  assign clk_run = (pstate == ddrp_pkg::PS_RUN);
  assign drv_en = (pstate == ddrp_pkg::PS_RUN);

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  logic [14:0] mr [4];
  logic cmd_take;
  logic chop_now;
  logic [1:0] bl_mode;
  ddrp_pkg::ddrp_cmd_type cmd_now;
  logic is_rw;

  // deselect or dead receivers mean no command
  assign cmd_take = ck_edge & bufen.cmd & pin_s.cke & ~pin_s.cs_n;
  assign cmd_now = ddrp_pkg::ddrp_cmd_type'({pin_s.ras_n, pin_s.cas_n, pin_s.we_n});
  assign is_rw = (cmd_now == ddrp_pkg::CMD_RD) | (cmd_now == ddrp_pkg::CMD_WR);
  assign bl_mode = mr[0][`DDRP_MR0_BL +: 2];

  // fixed modes override the a12 pin
  always_comb begin
    case (bl_mode)
      `DDRP_BL_OTF: chop_now = ~pin_s.addr[`DDRP_A_BC];
      `DDRP_BL_FIX4: chop_now = 1'b1;
      default: chop_now = 1'b0;
    endcase
  end

  // registered command record, one pclk pulse per command
  always_ff @(posedge pclk or negedge dev_rstn) begin
    if (!dev_rstn) begin
      dec <= '0;
    end else begin
      dec.valid <= cmd_take;
      if (cmd_take) begin
        dec.cmd <= cmd_now;
        dec.bank <= pin_s.ba;
        dec.addr <= pin_s.addr;
        dec.auto_pre <= pin_s.addr[`DDRP_A_AP];
        dec.chop <= is_rw & chop_now;
      end
    end
  end

  // mode registers loaded by mode register set
  always_ff @(posedge pclk or negedge dev_rstn) begin
    if (!dev_rstn) begin
      for (int i = 0; i < 4; i++) begin
        mr[i] <= `DDRP_MR_RST;
      end
    end else if (cmd_take && cmd_now == ddrp_pkg::CMD_MRS && !pin_s.ba[2]) begin
      mr[pin_s.ba[1:0]] <= pin_s.addr;
    end
  end

  // ------------------------------------------------------------
  // banks
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NBANK; g++) begin : g_bank
      logic hit;
      assign hit = (pin_s.ba == 3'(g));
      ddrp_bank u_bank (
        .clk(pclk),
        .rstn(dev_rstn),
        .ck_edge(ck_edge),
        .act(cmd_take & hit & (cmd_now == ddrp_pkg::CMD_ACT)),
        .pre(cmd_take & (cmd_now == ddrp_pkg::CMD_PRE) & (hit | pin_s.addr[`DDRP_A_AP])),
        .rw_ap(cmd_take & hit & is_rw & pin_s.addr[`DDRP_A_AP]),
        .chop(chop_now),
        .row_in(pin_s.addr),
        .open(bank_open[g]),
        .row()
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // power state
  // ------------------------------------------------------------
  ddrp_pkg::ddrp_pstate_type next_pstate;
  logic cke_fall;

  // controller keeps cke high across bursts, so entry needs no burst check
  assign cke_fall = ck_edge & ~pin_s.cke;

  always_comb begin
    next_pstate = pstate;
    case (pstate)
      ddrp_pkg::PS_RUN: begin
        if (cke_fall) begin
          if (!pin_s.cs_n && cmd_now == ddrp_pkg::CMD_REF && bank_open == '0) begin
            next_pstate = ddrp_pkg::PS_SREF;
          end else if (bank_open != '0) begin
            next_pstate = ddrp_pkg::PS_APD;
          end else begin
            next_pstate = ddrp_pkg::PS_PPD;
          end
        end
      end
      ddrp_pkg::PS_PPD, ddrp_pkg::PS_APD: begin
        if (ck_edge && pin_s.cke) begin
          next_pstate = ddrp_pkg::PS_RUN;
        end
      end
      ddrp_pkg::PS_SREF: begin
        if (pin_s.cke) begin
          next_pstate = ddrp_pkg::PS_RUN;
        end
      end
      default: next_pstate = ddrp_pkg::PS_RUN;
    endcase
  end

  // power state register
  always_ff @(posedge pclk or negedge dev_rstn) begin
    if (!dev_rstn) begin
      pstate <= ddrp_pkg::PS_RUN;
    end else begin
      pstate <= next_pstate;
    end
  end

  // ------------------------------------------------------------
  // termination and mask
  // ------------------------------------------------------------
  logic odt_q;
  logic rtt_en;
  logic x8_mode;
  logic tdqs_mode;

  assign rtt_en = mr[1][`DDRP_MR1_RTT0] | mr[1][`DDRP_MR1_RTT1] | mr[1][`DDRP_MR1_RTT2]
                | (mr[2][`DDRP_MR2_RTTWR +: 2] != 2'h0);
  assign tdqs_mode = x8_mode & mr[1][`DDRP_MR1_TDQS];
  assign dm_func_en = ~tdqs_mode;
  assign term_data_en = odt_q & rtt_en & bufen.odt;
  assign term_tdqs_en = term_data_en & tdqs_mode;

  // odt sampled on the crossing, even in power-down
  always_ff @(posedge pclk or negedge dev_rstn) begin
    if (!dev_rstn) begin
      odt_q <= 1'b0;
    end else if (ck_edge && bufen.odt) begin
      odt_q <= pin_s.odt & rtt_en;
    end
  end

  // ------------------------------------------------------------
  // write beats: write latency is not modelled
  // ------------------------------------------------------------
  logic [3:0] wr_beats;

  always_ff @(posedge pclk or negedge dev_rstn) begin
    if (!dev_rstn) begin
      wr_beats <= 4'h0;
      beat_valid <= 1'b0;
      beat_masked <= 1'b0;
    end else begin
      beat_valid <= 1'b0;
      if (cmd_take && cmd_now == ddrp_pkg::CMD_WR) begin
        wr_beats <= chop_now ? `DDRP_BEATS4 : `DDRP_BEATS8;
      end else if (dqs_edge && wr_beats != 4'h0) begin
        wr_beats <= wr_beats - 4'h1;
        beat_valid <= 1'b1;
        beat_masked <= pin_s.dm & dm_func_en;
      end
    end
  end

  // ------------------------------------------------------------
  // apb slave, zero wait states
  // ------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] rd_mux;
  logic hit_any;
  ddrp_pkg::ddrp_cmd_type last_cmd;

  assign x8_mode = ctrl[`DDRP_CTRL_X8];
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // last accepted command for software
  always_ff @(posedge pclk or negedge dev_rstn) begin
    if (!dev_rstn) begin
      last_cmd <= ddrp_pkg::CMD_NOP;
    end else if (cmd_take) begin
      last_cmd <= cmd_now;
    end
  end

  // read mux; unmapped reads as zero with error
  always_comb begin
    rd_mux = 32'h0000_0000;
    hit_any = 1'b1;
    case (paddr)
      `DDRP_OFS_CTRL: rd_mux = ctrl;
      `DDRP_OFS_STATUS: begin
        rd_mux[`DDRP_ST_PSTATE +: 2] = pstate;
        rd_mux[`DDRP_ST_INRST] = ~dev_rstn;
        rd_mux[`DDRP_ST_TERM] = term_data_en;
        rd_mux[`DDRP_ST_BANKS +: 8] = 8'(bank_open);
        rd_mux[`DDRP_ST_LASTCMD +: 3] = last_cmd;
      end
      `DDRP_OFS_MR0: rd_mux = {17'h0_0000, mr[0]};
      `DDRP_OFS_MR1: rd_mux = {17'h0_0000, mr[1]};
      `DDRP_OFS_MR2: rd_mux = {17'h0_0000, mr[2]};
      `DDRP_OFS_MR3: rd_mux = {17'h0_0000, mr[3]};
      default: hit_any = 1'b0;
    endcase
  end

  // read data latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // control register write in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `DDRP_CTRL_RST;
    end else if (psel && penable && pwrite && paddr == `DDRP_OFS_CTRL) begin
      ctrl <= {31'h0000_0000, pwdata[`DDRP_CTRL_X8]};
    end
  end

endmodule // ddrp_top

`default_nettype wire

// [ddrp_params.svh]
// constants for the ddr3 command/address pin decoder
// assumes inclusion by bare name from the top, bank and bench files
`ifndef DDRP_PARAMS_SVH
`define DDRP_PARAMS_SVH

// ------------------------------------------------------------
// apb register byte offsets
// ------------------------------------------------------------
`define DDRP_OFS_CTRL 8'h00
`define DDRP_OFS_STATUS 8'h04
`define DDRP_OFS_MR0 8'h08
`define DDRP_OFS_MR1 8'h0c
`define DDRP_OFS_MR2 8'h10
`define DDRP_OFS_MR3 8'h14

// ------------------------------------------------------------
// register fields and reset values
// ------------------------------------------------------------
`define DDRP_CTRL_X8 0
`define DDRP_CTRL_RST 32'h0000_0001
`define DDRP_ST_PSTATE 0
`define DDRP_ST_INRST 2
`define DDRP_ST_TERM 3
`define DDRP_ST_BANKS 8
`define DDRP_ST_LASTCMD 16
`define DDRP_MR_RST 15'h0000

// ------------------------------------------------------------
// mode register fields
// ------------------------------------------------------------
`define DDRP_MR0_BL 0
`define DDRP_MR1_RTT0 2
`define DDRP_MR1_RTT1 6
`define DDRP_MR1_RTT2 9
`define DDRP_MR1_TDQS 11
`define DDRP_MR2_RTTWR 9
`define DDRP_BL_FIX8 2'h0
`define DDRP_BL_OTF 2'h1
`define DDRP_BL_FIX4 2'h2

// ------------------------------------------------------------
// address pin functions and burst counts
// ------------------------------------------------------------
`define DDRP_A_AP 10
`define DDRP_A_BC 12
`define DDRP_BURST8_CK 3'h4
`define DDRP_BURST4_CK 3'h2
`define DDRP_BEATS8 4'h8
`define DDRP_BEATS4 4'h4

`endif

// [ddrp_pkg.sv]
// types shared by the ddr3 pin decoder files
// assumes nothing beyond a systemverilog compiler
`default_nettype none

package ddrp_pkg;

  // command code on {ras_n, cas_n, we_n} with cs_n low
  typedef enum logic [2:0] {
    CMD_MRS = 3'b000,
    CMD_REF = 3'b001,
    CMD_PRE = 3'b010,
    CMD_ACT = 3'b011,
    CMD_WR = 3'b100,
    CMD_RD = 3'b101,
    CMD_ZQ = 3'b110,
    CMD_NOP = 3'b111
  } ddrp_cmd_type;

  // power state of the device
  typedef enum logic [1:0] {
    PS_RUN = 2'b00,
    PS_PPD = 2'b01,
    PS_APD = 2'b10,
    PS_SREF = 2'b11
  } ddrp_pstate_type;

  // raw pin group from the memory controller
  typedef struct packed {
    logic ck;
    logic ck_n;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [14:0] addr;
    logic odt;
    logic dm;
    logic dqs;
  } ddrp_pins_type;

  // decoded command, one ck cycle
  typedef struct packed {
    logic valid;
    ddrp_cmd_type cmd;
    logic [2:0] bank;
    logic [14:0] addr;
    logic auto_pre;
    logic chop;
  } ddrp_dec_type;

  // input receiver enables
  typedef struct packed {
    logic clk;
    logic cke;
    logic odt;
    logic cmd;
    logic data;
  } ddrp_bufen_type;

endpackage : ddrp_pkg

`default_nettype wire

// [ddrp_sync.sv]
// two-flop synchroniser for a vector of pin levels
// assumes each bit is an independent level from another domain
`default_nettype none

module ddrp_sync #(
  parameter int W = 1
) (
  input wire logic clk, // sampling clock
  input wire logic rstn, // async reset, active low
  input wire logic [W-1:0] d, // asynchronous levels
  output logic [W-1:0] q // synchronised levels
);

  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // ddrp_sync

`default_nettype wire

// [ddrp_bank.sv]
// state of one internal bank: open row and pending auto-precharge
// assumes act, pre and rw_ap are one-cycle pulses on ck edges
`include "ddrp_params.svh"
`default_nettype none

module ddrp_bank (
  input wire logic clk, // pclk
  input wire logic rstn, // device reset, active low
  input wire logic ck_edge, // one ck crossing seen
  input wire logic act, // activate this bank
  input wire logic pre, // precharge this bank
  input wire logic rw_ap, // read/write with auto-precharge
  input wire logic chop, // chopped burst
  input wire logic [14:0] row_in, // row on activate
  output logic open, // a row is open
  output logic [14:0] row // open row address
);

  logic [2:0] ap_cnt;

  // open/close tracking; auto-precharge waits for burst to end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      open <= 1'b0;
      row <= 15'h0000;
      ap_cnt <= 3'h0;
    end else if (act) begin
      open <= 1'b1;
      row <= row_in;
    end else if (pre) begin
      open <= 1'b0;
      ap_cnt <= 3'h0;
    end else if (rw_ap) begin
      ap_cnt <= chop ? `DDRP_BURST4_CK : `DDRP_BURST8_CK;
    end else if (ck_edge && ap_cnt != 3'h0) begin
      ap_cnt <= ap_cnt - 3'h1;
      if (ap_cnt == 3'h1) begin
        open <= 1'b0;
      end
    end
  end

endmodule // ddrp_bank

`default_nettype wire

// [ddrp_top_sva.sv]
// assertions on the ports of the ddr3 command/address pin decoder
// assumes it is bound onto ddrp_top by the statement at the foot
`default_nettype none

module ddrp_sva #(
  parameter int NBANK = 8
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire ddrp_pkg::ddrp_pins_type pins, // controller pins
  input wire logic reset_pin_n, // device reset pin
  input wire ddrp_pkg::ddrp_dec_type dec, // decoded command
  input wire logic [NBANK-1:0] bank_open, // open banks
  input wire ddrp_pkg::ddrp_pstate_type pstate, // power state
  input wire ddrp_pkg::ddrp_bufen_type bufen, // receiver enables
  input wire logic clk_run, // clocks on
  input wire logic drv_en, // drivers on
  input wire logic term_data_en, // data termination
  input wire logic term_tdqs_en, // tdqs termination
  input wire logic dm_func_en, // ball is a mask
  input wire logic beat_valid, // write beat
  input wire logic beat_masked // beat dropped
);
  // ----------------------------------------------------------
  // one domain; pins are two pclk late, so decode looks back 2
  // ----------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_dec_pulse: assert property (dec.valid |=> !dec.valid)
    else $error("decode valid lasted more than one cycle");
  a_dec_select: assert property (dec.valid |-> !$past(pins.cs_n, 2))
    else $error("command decoded while deselected");
  a_dec_code: assert property (dec.valid |-> dec.cmd == $past({pins.ras_n, pins.cas_n, pins.we_n}, 2))
    else $error("command code differs from the strobes");
  a_dec_fields: assert property (dec.valid |-> dec.bank == $past(pins.ba, 2)
    && dec.auto_pre == $past(pins.addr[10], 2))
    else $error("bank or auto precharge field wrong");
  a_run_clk: assert property (clk_run == (pstate == ddrp_pkg::PS_RUN) && drv_en == clk_run)
    else $error("clocks or drivers wrong for power state");
  a_pd_bufs: assert property (pstate inside {ddrp_pkg::PS_PPD, ddrp_pkg::PS_APD} |-> bufen == 5'h1c)
    else $error("power-down receiver set wrong");
  a_sref_bufs: assert property (pstate == ddrp_pkg::PS_SREF |-> bufen == 5'h08)
    else $error("self-refresh receiver set wrong");
  a_apd_entry: assert property ($changed(pstate) && pstate == ddrp_pkg::PS_APD |-> bank_open != '0)
    else $error("active power-down with all banks idle");
  a_idle_entry: assert property ($changed(pstate) && pstate inside {ddrp_pkg::PS_PPD, ddrp_pkg::PS_SREF}
    |-> bank_open == '0)
    else $error("idle power state with a bank open");
  // exit on cke alone, ck stopped
  a_sref_exit: assert property (pstate == ddrp_pkg::PS_SREF && pins.cke ##1 pins.cke
    |-> ##[1:5] pstate == ddrp_pkg::PS_RUN)
    else $error("self-refresh not left on cke");
  a_tdqs_term: assert property (term_tdqs_en |-> term_data_en && !dm_func_en)
    else $error("tdqs termination without data termination");
  a_mask_beat: assert property (beat_valid && beat_masked |-> dm_func_en)
    else $error("beat masked while ball is not a mask");

  c_act: cover property (dec.valid && dec.cmd == ddrp_pkg::CMD_ACT);
  c_sref: cover property (pstate == ddrp_pkg::PS_SREF);
  c_mask: cover property (beat_valid && beat_masked);
endmodule // ddrp_sva

bind ddrp_top ddrp_sva #(.NBANK(NBANK)) sva_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pins(pins), .reset_pin_n(reset_pin_n), .dec(dec), .bank_open(bank_open), .pstate(pstate), .bufen(bufen),
  .clk_run(clk_run), .drv_en(drv_en), .term_data_en(term_data_en), .term_tdqs_en(term_tdqs_en),
  .dm_func_en(dm_func_en), .beat_valid(beat_valid), .beat_masked(beat_masked));

`default_nettype wire

// [ddrp_ctl_model.sv]
// behavioural memory controller driving the ddr3 pin group
// assumes the bench calls one task at a time; ck runs only in frames
`default_nettype none

module ddrp_ctl_model (
  output var ddrp_pkg::ddrp_pins_type pins // pin group to the device
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------
  // idle: ck stopped low, deselected
  // ----------------------------------------------------------
  initial begin
    pins = '0;
    pins.ck_n = 1'b1;
    pins.cke = 1'b1;
    pins.cs_n = 1'b1;
  end

  // one 307 ns ck frame; cke held over the whole frame
  task automatic cmd(input logic k, input logic s, input logic [2:0] c, input logic [2:0] b, input logic [14:0] a);
    #7; // off the pclk edge, phase unrelated
    pins.cke = k;
    pins.cs_n = s;
    {pins.ras_n, pins.cas_n, pins.we_n} = c;
    pins.ba = b;
    pins.addr = a;
    #100 {pins.ck, pins.ck_n} = 2'h2;
    #100 {pins.ck, pins.ck_n} = 2'h1;
    // released lines show the inverse; cs_n returns high
    pins.cs_n = 1'b1;
    {pins.ras_n, pins.cas_n, pins.we_n} = ~c;
    pins.ba = ~b;
    pins.addr = ~a;
    #100;
  endtask

  // one write beat: a dqs edge with dm held around it
  task automatic beat(input logic m);
    pins.dm = m;
    #50 pins.dqs = ~pins.dqs;
    #50 pins.dm = ~m;
  endtask

  task automatic set_odt(input logic v);
    #7 pins.odt = v;
  endtask

  // raise cke with ck stopped
  task automatic wake;
    pins.cke = 1'b1;
    #300;
  endtask
endmodule // ddrp_ctl_model

`default_nettype wire

// [tb_ddrp_top.sv]
// self-checking bench for the ddr3 pin decoder
// assumes the model and bound checker compile alongside
`include "ddrp_params.svh"
`default_nettype none

module tb_ddrp_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic reset_pin_n = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, clk_run, drv_en, term_data_en, term_tdqs_en, dm_func_en, beat_valid, beat_masked;
  logic [7:0] bank_open;
  ddrp_pkg::ddrp_pins_type pins;
  ddrp_pkg::ddrp_dec_type dec;
  ddrp_pkg::ddrp_pstate_type pstate;
  ddrp_pkg::ddrp_bufen_type bufen;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int nbeat = 0;
  int nmask = 0;
  logic [31:0] r;
  logic e;

  always #12.5 pclk = ~pclk;

  ddrp_ctl_model ctl_u (.pins(pins));
  ddrp_top #(.NBANK(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .reset_pin_n(reset_pin_n), .dec(dec), .bank_open(bank_open), .pstate(pstate), .bufen(bufen),
    .clk_run(clk_run), .drv_en(drv_en), .term_data_en(term_data_en), .term_tdqs_en(term_tdqs_en),
    .dm_func_en(dm_func_en), .beat_valid(beat_valid), .beat_masked(beat_masked));

  // ----------------------------------------------------------
  // beat counter and hang guard
  // ----------------------------------------------------------
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (beat_valid === 1'b1) begin
      nbeat <= nbeat + 1;
      nmask <= nmask + (beat_masked === 1'b1);
    end
    if (cyc == 8000) begin
      errors++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask

  // apb master, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk("prdata", x, r);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask

  task automatic c(input logic [2:0] op, input logic [2:0] b, input logic [14:0] a);
    ctl_u.cmd(1'b1, 1'b0, op, b, a);
  endtask

  task automatic dchk(input logic [2:0] op, input logic [2:0] b, input logic [14:0] a, input logic ap);
    chk("dec", 32'({op, b, a, ap}), 32'({dec.cmd, dec.bank, dec.addr, dec.auto_pre}));
  endtask

  // four beats, dm pattern 1 0 1 0
  task automatic beats(input logic [31:0] xm);
    int b0;
    int m0;
    b0 = nbeat;
    m0 = nmask;
    ctl_u.beat(1'b1);
    ctl_u.beat(1'b0);
    ctl_u.beat(1'b1);
    ctl_u.beat(1'b0);
    repeat (4) @(posedge pclk);
    chk("beats", 32'h0000_0004, 32'(nbeat - b0));
    chk("masked", xm, 32'(nmask - m0));
  endtask

  task automatic results;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(`DDRP_OFS_CTRL, `DDRP_CTRL_RST, 1'b0);
    rd(8'h40, 32'h0000_0000, 1'b1);
    c(ddrp_pkg::CMD_MRS, 3'h0, 15'h0001);
    c(ddrp_pkg::CMD_MRS, 3'h1, 15'h0804);
    rd(`DDRP_OFS_MR1, 32'h0000_0804, 1'b0);
    ctl_u.set_odt(1'b1);
    c(ddrp_pkg::CMD_NOP, 3'h0, 15'h0000);
    chk("term", 32'h0000_0006, 32'({term_data_en, term_tdqs_en, dm_func_en}));
    c(ddrp_pkg::CMD_ACT, 3'h2, 15'h1234);
    dchk(ddrp_pkg::CMD_ACT, 3'h2, 15'h1234, 1'b0);
    rd(`DDRP_OFS_STATUS, 32'h0003_0408, 1'b0);
    ctl_u.cmd(1'b1, 1'b1, ddrp_pkg::CMD_ACT, 3'h3, 15'h0555);
    dchk(ddrp_pkg::CMD_ACT, 3'h2, 15'h1234, 1'b0);
    chk("bank_open", 32'h0000_0004, 32'(bank_open));
    c(ddrp_pkg::CMD_WR, 3'h2, 15'h0008);
    chk("chop", 32'h0000_0001, 32'(dec.chop));
    beats(32'h0000_0000);
    c(ddrp_pkg::CMD_MRS, 3'h1, 15'h0004);
    c(ddrp_pkg::CMD_WR, 3'h2, 15'h0008);
    beats(32'h0000_0002);
    c(ddrp_pkg::CMD_RD, 3'h2, 15'h1400);
    dchk(ddrp_pkg::CMD_RD, 3'h2, 15'h1400, 1'b1);
    chk("chop", 32'h0000_0000, 32'(dec.chop));
    repeat (3) c(ddrp_pkg::CMD_NOP, 3'h0, 15'h0000);
    chk("bank_open", 32'h0000_0004, 32'(bank_open));
    c(ddrp_pkg::CMD_NOP, 3'h0, 15'h0000);
    chk("bank_open", 32'h0000_0000, 32'(bank_open));
    c(ddrp_pkg::CMD_ACT, 3'h1, 15'h0010);
    c(ddrp_pkg::CMD_ACT, 3'h5, 15'h0020);
    c(ddrp_pkg::CMD_PRE, 3'h1, 15'h0000);
    chk("bank_open", 32'h0000_0020, 32'(bank_open));
    c(ddrp_pkg::CMD_PRE, 3'h0, 15'h0400);
    chk("bank_open", 32'h0000_0000, 32'(bank_open));
    // power-down with a row open, then with all idle
    c(ddrp_pkg::CMD_ACT, 3'h0, 15'h0001);
    ctl_u.cmd(1'b0, 1'b0, ddrp_pkg::CMD_NOP, 3'h0, 15'h0000);
    chk("pstate", 32'h0000_0002, 32'(pstate));
    chk("bufen", 32'h0000_001c, 32'(bufen));
    chk("clk_drv", 32'h0000_0000, 32'({clk_run, drv_en}));
    c(ddrp_pkg::CMD_NOP, 3'h0, 15'h0000);
    chk("pstate", 32'h0000_0000, 32'(pstate));
    c(ddrp_pkg::CMD_PRE, 3'h0, 15'h0400);
    ctl_u.cmd(1'b0, 1'b0, ddrp_pkg::CMD_NOP, 3'h0, 15'h0000);
    chk("pstate", 32'h0000_0001, 32'(pstate));
    c(ddrp_pkg::CMD_NOP, 3'h0, 15'h0000);
    ctl_u.cmd(1'b0, 1'b0, ddrp_pkg::CMD_REF, 3'h0, 15'h0000);
    chk("pstate", 32'h0000_0003, 32'(pstate));
    chk("bufen", 32'h0000_0008, 32'(bufen));
    ctl_u.wake();
    chk("pstate", 32'h0000_0000, 32'(pstate));
    c(ddrp_pkg::CMD_MRS, 3'h1, 15'h0000);
    c(ddrp_pkg::CMD_NOP, 3'h0, 15'h0000);
    chk("term_data_en", 32'h0000_0000, 32'(term_data_en));
    // device reset pin clears state without pclk reset
    c(ddrp_pkg::CMD_ACT, 3'h3, 15'h0002);
    reset_pin_n <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("bank_open", 32'h0000_0000, 32'(bank_open));
    rd(`DDRP_OFS_MR0, 32'h0000_0000, 1'b0);
    rd(`DDRP_OFS_STATUS, 32'h0007_0004, 1'b0);
    reset_pin_n <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b1, `DDRP_OFS_CTRL, 32'hffff_fffe, r, e);
    rd(`DDRP_OFS_CTRL, 32'h0000_0000, 1'b0);
    results();
  end
endmodule // tb_ddrp_top

`default_nettype wire
